//--- cma_defines.svh
// Offsets, field positions, codes and timing for configuration memory access
`ifndef CMA_DEFINES_SVH
`define CMA_DEFINES_SVH
// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define CMA_OFF_COUNT  8'h88
`define CMA_OFF_CTRL   8'h89
`define CMA_OFF_ADRH   8'h8B
`define CMA_OFF_ADRL   8'h8C
`define CMA_OFF_NVDAT  8'h8D
`define CMA_OFF_SHDAT  8'h8E
`define CMA_OFF_ROMDAT 8'h8F
`define CMA_OFF_KEY    8'h90
`define CMA_OFF_PGSEL  8'h91
// ---------------------------------------------------------------------------
// Control fields and codes
// ---------------------------------------------------------------------------
`define CMA_BIT_TRIG   0
`define CMA_BIT_BUSY   2
`define CMA_BIT_FAIL   5
`define CMA_BIT_SNAP   6
`define CMA_ADRH_MSB   3
`define CMA_KEY_UNLOCK 8'hEA
`define CMA_RST_BYTE   8'h00
`define CMA_PTR_RST    12'h000
// ---------------------------------------------------------------------------
// Array geometry and timing
// ---------------------------------------------------------------------------
`define CMA_NUM_PAGES  6
`define CMA_BASE_BYTES 32
`define CMA_PAGE_BYTES 80
`define CMA_SHADOW_AW  9
`define CMA_ROM_AW     12
`define CMA_CLK_NS     10
`define CMA_NV_WR_NS   100
`define CMA_LVL_LOW    2'h0
`define CMA_LVL_MID    2'h1
`define CMA_LVL_HIGH   2'h2
`endif

//--- cma_host_model.sv
// Serial bus host model issuing register accesses
`timescale 1ns/1ps
module cma_host_model (
    input  wire logic         clk_i,
    output cma_pkg::cma_req_s req_o,
    output logic              xact_end_o,
    input  wire logic [7:0]   rdata_i,
    input  wire logic         rvalid_i
);
    initial begin
        req_o = '0;
        xact_end_o = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1 req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        #1 req_o = '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1 req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_i);
        #1 req_o = '0;
        d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
    endtask
    // High then low, one low write only
    task automatic setup(input logic [11:0] a);
        wr(8'h8B, {4'h0, a[11:8]});
        wr(8'h8C, a[7:0]);
    endtask
    task automatic stop();
        @(posedge clk_i);
        #1 xact_end_o = 1'b1;
        @(posedge clk_i);
        #1 xact_end_o = 1'b0;
    endtask
endmodule

//--- cma_nv_store.sv
// Non-volatile array with one write port and two read ports
`timescale 1ns/1ps
module cma_nv_store #(
    parameter int AW = 9
) (
    input  wire logic          clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [7:0]    wdata_i,
    input  wire logic [AW-1:0] raddr_a_i,
    output logic      [7:0]    rdata_a_o,
    input  wire logic [AW-1:0] raddr_b_i,
    output logic      [7:0]    rdata_b_o
);
    // -----------------------------------------------------------------------
    // Storage
    // -----------------------------------------------------------------------
    logic [7:0] mem [0:(2**AW)-1];
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end
    assign rdata_a_o = mem[raddr_a_i];
    assign rdata_b_o = mem[raddr_b_i];
endmodule

//--- cma_page_decode.sv
// Decoder from two three-level strap pins to a start-up page index
`timescale 1ns/1ps
`include "cma_defines.svh"
module cma_page_decode (
    input  wire logic [1:0] lvl_a_i,
    input  wire logic [1:0] lvl_b_i,
    output logic      [2:0] page_o
);
    // -----------------------------------------------------------------------
    // Level to digit, nine combinations folded onto the pages
    // -----------------------------------------------------------------------
    logic [3:0] da;
    logic [3:0] db;
    logic [3:0] idx;
    always_comb begin
        da = (lvl_a_i == `CMA_LVL_HIGH) ? 4'h2 :
             (lvl_a_i == `CMA_LVL_LOW)  ? 4'h0 : 4'h1;
        db = (lvl_b_i == `CMA_LVL_HIGH) ? 4'h2 :
             (lvl_b_i == `CMA_LVL_LOW)  ? 4'h0 : 4'h1;
        idx = 4'((da * 4'h3) + db);
        if (idx < 4'(`CMA_NUM_PAGES)) begin
            page_o = idx[2:0];
        end else begin
            page_o = 3'(idx - 4'(`CMA_NUM_PAGES));
        end
    end
endmodule

//--- cma_pkg.sv
// Types shared by the configuration memory access block
package cma_pkg;
    // -----------------------------------------------------------------------
    // Sequencer states
    // -----------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_STRAP = 3'b000,
        ST_LOAD  = 3'b001,
        ST_IDLE  = 3'b010,
        ST_PROG  = 3'b011,
        ST_SNAP  = 3'b100
    } cma_state_e;
    // -----------------------------------------------------------------------
    // Register access request and start-up load carriers
    // -----------------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cma_req_s;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } cma_cfg_s;
endpackage

//--- cma_top.sv
// Register-mapped access to shadow, non-volatile and ROM configuration memory
// Summary of operation
// - Six start-up pages, chosen by two three-level strap pins.
// - Chosen page is loaded into configuration registers after every reset.
// - While programming, control bit 2 reads 1 and non-volatile reads block.
// - Unlock key 0xEA must be in the key register before programming.
// - Writing 1 to control bit 0 copies whole shadow into non-volatile.
// - Each successful programming cycle adds one to the cycle counter.
// - Failed programming sets control bit 5 and locks the device up.
// - A later successful programming cycle clears the lockup.
// - Shadow address: bit 8 in high register bit 0, low byte in low.
// - Shadow port read in same transaction returns byte at the address.
// - Each further port access in the transaction advances the address.
// - Transaction end closes memory access; new address setup needed.
// - Non-volatile port read returns byte at the same nine-bit address.
// - Further non-volatile accesses increment; access ends with transaction.
// - ROM address: bits 11..8 in high register bits 3..0, low in low.
// - ROM port read returns ROM byte, auto-increments, ends with transaction.
// - Control bit 6 copies live registers into the selected shadow page.
`timescale 1ns/1ps
`include "cma_defines.svh"
module cma_top #(
    parameter int BASE_BYTES   = `CMA_BASE_BYTES,
    parameter int PAGE_BYTES   = `CMA_PAGE_BYTES,
    parameter int NV_WR_CYCLES =
        (`CMA_NV_WR_NS + `CMA_CLK_NS - 1) / `CMA_CLK_NS
) (
    input  wire logic             MCLK_I,
    input  wire logic             RST_I,
    input  wire cma_pkg::cma_req_s REG_REQ_I,
    input  wire logic             XACT_END_I,
    output logic      [7:0]       REG_RDATA_O,
    output logic                  REG_RVALID_O,
    input  wire logic [1:0]       PAGE_PIN_A_I,
    input  wire logic [1:0]       PAGE_PIN_B_I,
    input  wire logic             NV_FAULT_I,
    output logic      [7:0]       LIVE_ADDR_O,
    input  wire logic [7:0]       LIVE_DATA_I,
    output logic                  CFG_WR_O,
    output cma_pkg::cma_cfg_s     CFG_O,
    output logic                  CFG_READY_O
);
    // -----------------------------------------------------------------------
    // Geometry and checks
    // -----------------------------------------------------------------------
    localparam int SAW = `CMA_SHADOW_AW;
    localparam int SH_DEPTH = 2**SAW;
    localparam logic [SAW:0] SH_END = (SAW+1)'(SH_DEPTH);
    localparam logic [SAW:0] BASE_N = (SAW+1)'(BASE_BYTES);
    localparam logic [SAW:0] PAGE_N = (SAW+1)'(PAGE_BYTES);
    localparam logic [SAW:0] LOAD_N = (SAW+1)'(BASE_BYTES + PAGE_BYTES);
    localparam logic [15:0] WR_RELOAD = 16'(NV_WR_CYCLES - 1);
    if (BASE_BYTES + `CMA_NUM_PAGES * PAGE_BYTES > SH_DEPTH ||
        BASE_BYTES + PAGE_BYTES > 256 || PAGE_BYTES > 256 ||
        PAGE_BYTES < 1 || NV_WR_CYCLES < 1 || NV_WR_CYCLES > 65536) begin
        $error("cma_top: parameters out of range");
    end
    // -----------------------------------------------------------------------
    // State
    // -----------------------------------------------------------------------
    cma_pkg::cma_state_e st_q;
    cma_pkg::cma_cfg_s   cfg_q;
    logic [SAW:0]        idx_q;
    logic [15:0]         wait_q;
    logic [11:0]         ptr_q;
    logic [7:0]          count_q, key_q, adrh_q, adrl_q, pgsel_q, rdata_q;
    logic [2:0]          page_q;
    logic                fault_q, fail_q, trig_q, snap_q, armed_q;
    logic                rvalid_q, cfg_wr_q, loaded_q, ready_q;
    logic [7:0]          shadow_mem [0:SH_DEPTH-1];
    // -----------------------------------------------------------------------
    // Request decode
    // -----------------------------------------------------------------------
    logic                acc, hit_nv, hit_sh, hit_rom, port_acc;
    logic                busy, key_ok, ctrl_wr, nv_we;
    logic [2:0]          page_pin;
    logic [SAW-1:0]      sh_ptr, load_addr, snap_addr;
    logic [7:0]          sh_rd, nv_rd_load, nv_rd_host, ctrl_rd, rd_mux;
    assign acc     = REG_REQ_I.wr | REG_REQ_I.rd;
    assign hit_nv  = acc && (REG_REQ_I.addr == `CMA_OFF_NVDAT);
    assign hit_sh  = acc && (REG_REQ_I.addr == `CMA_OFF_SHDAT);
    assign hit_rom = acc && (REG_REQ_I.addr == `CMA_OFF_ROMDAT);
    assign port_acc = armed_q && (hit_nv || hit_sh || hit_rom);
    assign busy    = (st_q == cma_pkg::ST_PROG);
    assign key_ok  = (key_q == `CMA_KEY_UNLOCK);
    assign ctrl_wr = REG_REQ_I.wr && (REG_REQ_I.addr == `CMA_OFF_CTRL);
    assign sh_ptr  = ptr_q[SAW-1:0];
    assign sh_rd   = shadow_mem[sh_ptr];
    assign snap_addr = SAW'(BASE_N + SAW'(pgsel_q[2:0]) * PAGE_N + idx_q);
    assign nv_we   = busy && (wait_q == 16'h0000) && (idx_q != SH_END);
    // Base bytes first, then the strapped page
    always_comb begin
        if (idx_q < BASE_N) begin
            load_addr = idx_q[SAW-1:0];
        end else begin
            load_addr = SAW'(BASE_N + SAW'(page_q) * PAGE_N +
                             (idx_q - BASE_N));
        end
    end
    // -----------------------------------------------------------------------
    // Submodules
    // -----------------------------------------------------------------------
    cma_page_decode u_page (
        .lvl_a_i (PAGE_PIN_A_I),
        .lvl_b_i (PAGE_PIN_B_I),
        .page_o  (page_pin)
    );
    cma_nv_store #(.AW(SAW)) u_nv (
        .clk_i     (MCLK_I),
        .we_i      (nv_we),
        .waddr_i   (idx_q[SAW-1:0]),
        .wdata_i   (shadow_mem[idx_q[SAW-1:0]]),
        .raddr_a_i (load_addr),
        .rdata_a_o (nv_rd_load),
        .raddr_b_i (sh_ptr),
        .rdata_b_o (nv_rd_host)
    );

    // ROM contents fixed in the mask
    function automatic logic [7:0] rom_byte(input logic [11:0] a);
        rom_byte = a[7:0] ^ {a[11:8], a[11:8]};
    endfunction
    // -----------------------------------------------------------------------
    // Sequencer
    // -----------------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            st_q     <= cma_pkg::ST_STRAP;
            idx_q    <= '0;
            wait_q   <= 16'h0000;
            fault_q  <= 1'b0;
            page_q   <= 3'h0;
            loaded_q <= 1'b0;
            cfg_wr_q <= 1'b0;
            cfg_q    <= '0;
        end else begin
            cfg_wr_q <= 1'b0;
            unique case (st_q)
                cma_pkg::ST_STRAP: begin
                    page_q <= page_pin;
                    idx_q  <= '0;
                    st_q   <= cma_pkg::ST_LOAD;
                end
                cma_pkg::ST_LOAD: begin
                    cfg_wr_q   <= 1'b1;
                    cfg_q.addr <= idx_q[7:0];
                    cfg_q.data <= nv_rd_load;
                    idx_q      <= idx_q + 1'b1;
                    if (idx_q == LOAD_N - 1'b1) begin
                        st_q     <= cma_pkg::ST_IDLE;
                        loaded_q <= 1'b1;
                    end
                end
                cma_pkg::ST_IDLE: begin
                    idx_q  <= '0;
                    wait_q <= 16'h0000;
                    if (trig_q && key_ok) begin
                        st_q    <= cma_pkg::ST_PROG;
                        fault_q <= 1'b0;
                    end else if (snap_q) begin
                        st_q <= cma_pkg::ST_SNAP;
                    end
                end
                cma_pkg::ST_PROG: begin
                    if (NV_FAULT_I) begin
                        fault_q <= 1'b1;
                    end
                    if (wait_q != 16'h0000) begin
                        wait_q <= wait_q - 1'b1;
                    end else if (idx_q == SH_END) begin
                        st_q <= cma_pkg::ST_IDLE;
                    end else begin
                        idx_q  <= idx_q + 1'b1;
                        wait_q <= WR_RELOAD;
                    end
                end
                cma_pkg::ST_SNAP: begin
                    idx_q <= idx_q + 1'b1;
                    if (idx_q == PAGE_N - 1'b1) begin
                        st_q <= cma_pkg::ST_IDLE;
                    end
                end
                default: begin
                    st_q <= cma_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Result of a programming cycle
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            fail_q  <= 1'b0;
            count_q <= `CMA_RST_BYTE;
        end else if (busy && wait_q == 16'h0000 && idx_q == SH_END) begin
            if (fault_q || NV_FAULT_I) begin
                fail_q <= 1'b1;
            end else begin
                fail_q  <= 1'b0;
                count_q <= count_q + 1'b1;
            end
        end
    end

    // Device runs only when loaded and not locked up
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= loaded_q && !fail_q;
        end
    end

    // -----------------------------------------------------------------------
    // Control register and key
    // -----------------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            trig_q <= 1'b0;
        end else if (ctrl_wr && REG_REQ_I.wdata[`CMA_BIT_TRIG] &&
                     st_q == cma_pkg::ST_IDLE) begin
            trig_q <= 1'b1;
        end else if (st_q == cma_pkg::ST_IDLE) begin
            trig_q <= 1'b0;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            snap_q <= 1'b0;
        end else if (ctrl_wr && REG_REQ_I.wdata[`CMA_BIT_SNAP] &&
                     st_q == cma_pkg::ST_IDLE &&
                     pgsel_q < 8'(`CMA_NUM_PAGES)) begin
            snap_q <= 1'b1;
        end else if (st_q == cma_pkg::ST_SNAP && idx_q == PAGE_N - 1'b1) begin
            snap_q <= 1'b0;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            key_q   <= `CMA_RST_BYTE;
            adrh_q  <= `CMA_RST_BYTE;
            adrl_q  <= `CMA_RST_BYTE;
            pgsel_q <= `CMA_RST_BYTE;
        end else if (REG_REQ_I.wr) begin
            unique case (REG_REQ_I.addr)
                `CMA_OFF_KEY:   key_q   <= REG_REQ_I.wdata;
                `CMA_OFF_ADRH:  adrh_q  <= REG_REQ_I.wdata;
                `CMA_OFF_ADRL:  adrl_q  <= REG_REQ_I.wdata;
                `CMA_OFF_PGSEL: pgsel_q <= REG_REQ_I.wdata;
                default:        key_q   <= key_q;
            endcase
        end
    end

    // -----------------------------------------------------------------------
    // Address pointer, one transaction long
    // -----------------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            ptr_q   <= `CMA_PTR_RST;
            armed_q <= 1'b0;
        end else if (XACT_END_I) begin
            armed_q <= 1'b0;
        end else if (REG_REQ_I.wr && REG_REQ_I.addr == `CMA_OFF_ADRL) begin
            ptr_q   <= {adrh_q[`CMA_ADRH_MSB:0], REG_REQ_I.wdata};
            armed_q <= 1'b1;
        end else if (port_acc) begin
            ptr_q <= ptr_q + 1'b1;
        end
    end

    // -----------------------------------------------------------------------
    // Shadow array writes
    // -----------------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (st_q == cma_pkg::ST_SNAP) begin
            shadow_mem[snap_addr] <= LIVE_DATA_I;
        end else if (port_acc && hit_sh && REG_REQ_I.wr && !busy) begin
            shadow_mem[sh_ptr] <= REG_REQ_I.wdata;
        end
    end

    // -----------------------------------------------------------------------
    // Read data
    // -----------------------------------------------------------------------
    always_comb begin
        ctrl_rd = `CMA_RST_BYTE;
        ctrl_rd[`CMA_BIT_TRIG] = trig_q;
        ctrl_rd[`CMA_BIT_BUSY] = busy;
        ctrl_rd[`CMA_BIT_FAIL] = fail_q;
        ctrl_rd[`CMA_BIT_SNAP] = snap_q;
        unique case (REG_REQ_I.addr)
            `CMA_OFF_COUNT:  rd_mux = count_q;
            `CMA_OFF_CTRL:   rd_mux = ctrl_rd;
            `CMA_OFF_ADRH:   rd_mux = adrh_q;
            `CMA_OFF_ADRL:   rd_mux = adrl_q;
            `CMA_OFF_NVDAT:  rd_mux = (armed_q && !busy) ? nv_rd_host :
                                      `CMA_RST_BYTE;
            `CMA_OFF_SHDAT:  rd_mux = armed_q ? sh_rd :
                                      `CMA_RST_BYTE;
            `CMA_OFF_ROMDAT: rd_mux = armed_q ? rom_byte(ptr_q) :
                                      `CMA_RST_BYTE;
            `CMA_OFF_KEY:    rd_mux = key_q;
            `CMA_OFF_PGSEL:  rd_mux = pgsel_q;
            default:         rd_mux = `CMA_RST_BYTE;
        endcase
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            rdata_q  <= `CMA_RST_BYTE;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= REG_REQ_I.rd;
            if (REG_REQ_I.rd) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign REG_RDATA_O  = rdata_q;
    assign REG_RVALID_O = rvalid_q;
    assign LIVE_ADDR_O  = idx_q[7:0];
    assign CFG_WR_O     = cfg_wr_q;
    assign CFG_O        = cfg_q;
    assign CFG_READY_O  = ready_q;

    // -----------------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------------
    a_busy_bit: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (busy && REG_REQ_I.rd && REG_REQ_I.addr == `CMA_OFF_CTRL)
        |=> REG_RDATA_O[`CMA_BIT_BUSY]) else $error("busy bit not set");
    a_nv_blocked: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (busy && REG_REQ_I.rd && REG_REQ_I.addr == `CMA_OFF_NVDAT)
        |=> REG_RDATA_O == `CMA_RST_BYTE) else $error("nv read not blocked");
    a_key_gate: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (st_q == cma_pkg::ST_IDLE && !key_ok && trig_q)
        |=> st_q != cma_pkg::ST_PROG) else $error("program without key");
    a_trig_clear: assert property (@(posedge MCLK_I) disable iff (RST_I)
        busy |-> !trig_q) else $error("trigger stuck during program");
    a_count_step: assert property (@(posedge MCLK_I) disable iff (RST_I)
        ($past(busy) && st_q == cma_pkg::ST_IDLE && !fail_q)
        |-> count_q == 8'($past(count_q) + 1'b1))
        else $error("counter did not step");
    a_fail_lock: assert property (@(posedge MCLK_I) disable iff (RST_I)
        fail_q |=> !CFG_READY_O) else $error("ready while locked up");
    a_ptr_step: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (port_acc && !XACT_END_I) |=> ptr_q == 12'($past(ptr_q) + 1'b1))
        else $error("pointer did not advance");
    a_xact_end: assert property (@(posedge MCLK_I) disable iff (RST_I)
        XACT_END_I |=> !armed_q) else $error("access after end");
    a_unarmed_rd: assert property (@(posedge MCLK_I)
        disable iff (RST_I)
        (!armed_q && REG_REQ_I.rd && REG_REQ_I.addr == `CMA_OFF_SHDAT)
        |=> REG_RDATA_O == `CMA_RST_BYTE) else $error("read while closed");
    a_shadow_rd: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (armed_q && REG_REQ_I.rd && REG_REQ_I.addr == `CMA_OFF_SHDAT)
        |=> REG_RDATA_O == $past(sh_rd)) else $error("shadow read wrong");
    a_load_done: assert property (@(posedge MCLK_I) disable iff (RST_I)
        ($past(RST_I) && !RST_I) |-> ##[1:600] loaded_q)
        else $error("start-up load missing");
endmodule

//--- config_memory_access_bench.sv
// Self-checking bench for configuration memory access
`timescale 1ns/1ps
module config_memory_access_bench;
    logic              MCLK_I = 1'b0;
    logic              RST_I = 1'b1;
    logic              fault = 1'b0;
    logic [1:0]        pin_a = 2'h0;
    logic [1:0]        pin_b = 2'h1;
    cma_pkg::cma_req_s req;
    cma_pkg::cma_cfg_s cfg;
    logic              xend, rvalid, cfg_wr, ready;
    logic [7:0]        rdata, live_addr, got;
    int                miscompares = 0;
    int                cmp_count = 0;
    always #5 MCLK_I = ~MCLK_I;
    cma_host_model u_host (.clk_i(MCLK_I), .req_o(req), .xact_end_o(xend),
        .rdata_i(rdata), .rvalid_i(rvalid));
    cma_top #(.NV_WR_CYCLES(1)) u_dut (.MCLK_I(MCLK_I), .RST_I(RST_I),
        .REG_REQ_I(req), .XACT_END_I(xend), .REG_RDATA_O(rdata),
        .REG_RVALID_O(rvalid), .PAGE_PIN_A_I(pin_a), .PAGE_PIN_B_I(pin_b),
        .NV_FAULT_I(fault), .LIVE_ADDR_O(live_addr),
        .LIVE_DATA_I(live_addr ^ 8'h5A), .CFG_WR_O(cfg_wr), .CFG_O(cfg),
        .CFG_READY_O(ready));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        u_host.rd(a, got);
        chk(got, e);
    endtask
    task automatic prog(input logic f);
        u_host.wr(8'h90, 8'hEA);
        fault = f;
        u_host.wr(8'h89, 8'h01);
        @(posedge MCLK_I);
        u_host.rd(8'h89, got);
        chk(got & 8'h05, 8'h04);
        rdchk(8'h8D, 8'h00);
        repeat (520) @(posedge MCLK_I);
        #1 fault = 1'b0;
        u_host.wr(8'h90, 8'h00);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge MCLK_I);
        #1 RST_I = 1'b0;
        rdchk(8'h89, 8'h00);
        rdchk(8'h88, 8'h00);
        rdchk(8'h90, 8'h00);
        rdchk(8'h8A, 8'h00);
        repeat (120) @(posedge MCLK_I);
        chk({7'h00, ready}, 8'h01);
        $display("test reset done");
        u_host.wr(8'h91, 8'h01);
        u_host.wr(8'h89, 8'h40);
        repeat (90) @(posedge MCLK_I);
        rdchk(8'h89, 8'h00);
        u_host.setup(12'h070);
        for (int i = 0; i < 3; i++)
            rdchk(8'h8E, 8'(i) ^ 8'h5A);
        u_host.stop();
        rdchk(8'h8E, 8'h00);
        $display("test shadow done");
        u_host.setup(12'h000);
        for (int i = 0; i < 32; i++)
            u_host.wr(8'h8E, 8'(i) ^ 8'hC3);
        u_host.stop();
        u_host.wr(8'h89, 8'h01);
        repeat (3) @(posedge MCLK_I);
        rdchk(8'h89, 8'h00);
        prog(1'b0);
        rdchk(8'h89, 8'h00);
        rdchk(8'h88, 8'h01);
        rdchk(8'h90, 8'h00);
        u_host.setup(12'h071);
        rdchk(8'h8D, 8'h5B);
        rdchk(8'h8D, 8'h58);
        u_host.stop();
        $display("test program done");
        prog(1'b1);
        rdchk(8'h89, 8'h20);
        rdchk(8'h88, 8'h01);
        chk({7'h00, ready}, 8'h00);
        prog(1'b0);
        rdchk(8'h89, 8'h00);
        rdchk(8'h88, 8'h02);
        chk({7'h00, ready}, 8'h01);
        $display("test fault done");
        u_host.setup(12'h345);
        rdchk(8'h8F, 8'h76);
        rdchk(8'h8F, 8'h75);
        u_host.stop();
        rdchk(8'h8F, 8'h00);
        $display("test rom done");
        @(posedge MCLK_I);
        #1 RST_I = 1'b1;
        pin_a = 2'h2;
        repeat (2) @(posedge MCLK_I);
        #1 RST_I = 1'b0;
        repeat (2) @(posedge MCLK_I);
        for (int i = 0; i < 112; i++) begin
            #1 chk({7'h00, cfg_wr}, 8'h01);
            chk(cfg.addr, 8'(i));
            chk(cfg.data, (i < 32) ? 8'(i) ^ 8'hC3 : 8'(i - 32) ^ 8'h5A);
            @(posedge MCLK_I);
        end
        rdchk(8'h88, 8'h00);
        chk({7'h00, ready}, 8'h01);
        $display("test reload done");
        conclude();
    end
endmodule
